// ### cfisr_consts.svh
/*
  offsets, field positions, reset values and bus codes of the
  status and interrupt register block.
  assumes nothing; definitions only, included by bare name.
*/
`ifndef CFISR_CONSTS_SVH
`define CFISR_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CFISR_OFF_FIFO_CTRL   32'h0000_0000
`define CFISR_OFF_FIFO_PTR    32'h0000_0004
`define CFISR_OFF_INT_FLAGS   32'h0000_0008
`define CFISR_OFF_INT_ENABLES 32'h0000_000C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CFISR_DMA_BUFFER_COUNT_SEL_LSB  13
`define CFISR_FSA_LSB    0
`define CFISR_FBP_LSB    8
`define CFISR_FIFO_NEXT_READ_POINTER_LSB   0
`define CFISR_TX_BUS_OFF_BIT   13
`define CFISR_TX_ERROR_PASSIVE_BIT   12
`define CFISR_RX_ERROR_PASSIVE_BIT   11
`define CFISR_TX_WARNING_BIT  10
`define CFISR_RX_WARNING_BIT  9
`define CFISR_ANY_WARNING_BIT  8
`define CFISR_IVR_BIT    7
`define CFISR_WAK_BIT    6
`define CFISR_ERR_BIT    5
`define CFISR_FIFO_BIT   3
`define CFISR_RBOV_BIT   2
`define CFISR_RB_BIT     1
`define CFISR_TB_BIT     0

// ----------------------------------------------------------------
// implemented flag/enable bits and reset values
// ----------------------------------------------------------------
`define CFISR_FLAG_MASK  8'hEF
`define CFISR_CTRL_RST   3'h0
`define CFISR_FSA_RST    5'h00
`define CFISR_EN_RST     8'h00
`define CFISR_FLAG_RST   8'h00

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define CFISR_RESP_OKAY   2'h0
`define CFISR_RESP_SLVERR 2'h2

`endif

// ### cfisr_pkg.sv
/*
  types shared by the status and interrupt register block.
  assumes the constants header is included by the user files.
*/
package cfisr_pkg;
  // register read word before zero extension
  typedef logic [15:0] cfisr_half_type;
  // interrupt flag or enable byte
  typedef logic [7:0]  cfisr_byte_type;
  // bus response code
  typedef logic [1:0]  cfisr_resp_type;
endpackage

// ### cfisr_rise.sv
/*
  rising-edge detector for a group of level inputs.
  assumes inputs synchronous to aclk.
*/
`timescale 1ns/10ps
`default_nettype none
module cfisr_rise
  import cfisr_pkg::*;
#(
  parameter int W = 6
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // levels in, one-cycle pulse out
  input  wire logic [W-1:0] level,
  output logic              any_rise
);
  logic [W-1:0] level_r;

  // ----------------------------------------------------------------
  // previous level
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_r <= '0;
    end else begin
      level_r <= level;
    end
  end

  // a state entered while already active elsewhere still counts
  assign any_rise = |(level & ~level_r);
endmodule // cfisr_rise
`default_nettype wire

// ### cfisr_flags.sv
/*
  sticky clear-only flag bank: hardware sets, software clears.
  assumes one-cycle set pulses and clear strobes.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cfisr_consts.svh"
module cfisr_flags
  import cfisr_pkg::*;
(
  // clock and reset
  input  wire logic           aclk,
  input  wire logic           aresetn,
  // set pulses and clear strobes
  input  wire cfisr_byte_type set_evt,
  input  wire cfisr_byte_type clr,
  // flag state
  output cfisr_byte_type      flag_r
);
  cfisr_byte_type flag_nxt;

  // set wins over clear so no event is lost during a clear
  assign flag_nxt = ((flag_r & ~clr) | set_evt) & `CFISR_FLAG_MASK;

  // ----------------------------------------------------------------
  // flag storage
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= `CFISR_FLAG_RST;
    end else begin
      flag_r <= flag_nxt;
    end
  end
endmodule // cfisr_flags
`default_nettype wire

// ### cfisr_regs.sv
/*
  status and interrupt registers of the bus controller, reached over
  an AXI4-Lite slave port.
  assumes the protocol engine drives error levels and one-cycle event
  pulses synchronous to aclk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cfisr_consts.svh"

// Functional notes
// - bit 13 of flags reads set while transmitter is bus-off.
// - bit 12 reads set while transmitter is error-passive.
// - bit 11 reads set while receiver is error-passive.
// - bit 10 reads set while transmitter reached warning level.
// - bit 9 reads set while receiver reached warning level.
// - bit 8 reads set while either side is at warning.
// - bit 7 sets on invalid message; software can only clear it.
// - bit 6 sets on bus wake-up activity; clear-only.
// - bit 5 sets on any entry into error states of bits 13..8.
// - bit 3 sets when receive FIFO becomes almost full.
// - bit 2 sets on receive buffer overflow.
// - bit 1 sets when a message is stored in a receive buffer.
// - bit 0 sets on a transmit buffer event.
// - read-only six-bit next-read pointer names the buffer to read.
// - unimplemented bits read zero and ignore writes.
// - each flag of bits 7..0 has a read-write enable at the same position; bits 13..8 have none.
module cfisr_regs
  import cfisr_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // error state levels from the protocol engine
  input  wire logic        tx_bus_off,
  input  wire logic        tx_error_passive,
  input  wire logic        rx_error_passive,
  input  wire logic        tx_warning,
  input  wire logic        rx_warning,
  // event pulses from the protocol engine
  input  wire logic        invalid_msg_evt,
  input  wire logic        wakeup_evt,
  input  wire logic        fifo_almost_full_evt,
  input  wire logic        rx_overflow_evt,
  input  wire logic        rx_buffer_evt,
  input  wire logic        tx_buffer_evt,
  // fifo pointers from the buffer logic
  input  wire logic [5:0]  fifo_write_pointer,
  input  wire logic [5:0]  fifo_next_read_pointer,
  // configuration to the buffer logic
  output logic [2:0]       dma_buffer_count_sel,
  output logic [4:0]       fifo_area_start,
  // interrupt request
  output logic             irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // word address match; low two bits ignored for aligned words
  function automatic logic addr_is(input logic [31:0] a,
                                   input logic [31:0] off);
    addr_is = (a[31:2] == off[31:2]);
  endfunction

  // any of the four registers
  function automatic logic addr_ok(input logic [31:0] a);
    addr_ok = addr_is(a, `CFISR_OFF_FIFO_CTRL)   ||
              addr_is(a, `CFISR_OFF_FIFO_PTR)    ||
              addr_is(a, `CFISR_OFF_INT_FLAGS)   ||
              addr_is(a, `CFISR_OFF_INT_ENABLES);
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [31:0]    awaddr_r;
  logic           aw_held_r;
  logic [31:0]    wdata_r;
  logic [3:0]     wstrb_r;
  logic           w_held_r;
  logic           bvalid_r;
  cfisr_resp_type bresp_r;
  logic           rvalid_r;
  logic [31:0]    rdata_r;
  cfisr_resp_type rresp_r;
  logic           wr_go;
  logic           wr_ctrl;
  logic           wr_flags;
  logic           wr_en;
  logic [2:0]     dma_buffer_count_sel_r;
  logic [4:0]     fsa_r;
  cfisr_byte_type en_r;
  cfisr_byte_type flag_r;
  cfisr_byte_type flag_set;
  cfisr_byte_type flag_clr;
  logic           err_rise;
  logic           any_warning;
  logic [5:0]     err_levels;
  cfisr_half_type flags_word;
  cfisr_half_type rd_word;
  logic           ar_take;

  // ----------------------------------------------------------------
  // write channel handshake
  // ----------------------------------------------------------------
  // address and data are each held until both are here; nothing new
  // is taken while a response is pending, which bounds one write
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign wr_go         = aw_held_r && w_held_r && !bvalid_r;

  // capture address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= 32'h0000_0000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_r <= 1'b0;
    end
  end

  // capture data and strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_r <= 1'b0;
    end
  end

  // write response; unmapped addresses get slverr and change nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `CFISR_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= addr_ok(awaddr_r) ? `CFISR_RESP_OKAY
                                    : `CFISR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // register selects for the committed write
  assign wr_ctrl  = wr_go && addr_is(awaddr_r, `CFISR_OFF_FIFO_CTRL);
  assign wr_flags = wr_go && addr_is(awaddr_r, `CFISR_OFF_INT_FLAGS);
  assign wr_en    = wr_go && addr_is(awaddr_r, `CFISR_OFF_INT_ENABLES);

  // ----------------------------------------------------------------
  // fifo control fields
  // ----------------------------------------------------------------
  // each field lives in one byte lane, so its strobe gates it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dma_buffer_count_sel_r <= `CFISR_CTRL_RST;
      fsa_r   <= `CFISR_FSA_RST;
    end else if (wr_ctrl) begin
      if (wstrb_r[1]) begin
        dma_buffer_count_sel_r <= wdata_r[`CFISR_DMA_BUFFER_COUNT_SEL_LSB +: 3];
      end
      if (wstrb_r[0]) begin
        fsa_r <= wdata_r[`CFISR_FSA_LSB +: 5];
      end
    end
  end

  assign dma_buffer_count_sel = dma_buffer_count_sel_r;
  assign fifo_area_start      = fsa_r;

  // ----------------------------------------------------------------
  // interrupt enables
  // ----------------------------------------------------------------
  // bit 4 and the upper byte are not stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_r <= `CFISR_EN_RST;
    end else if (wr_en && wstrb_r[0]) begin
      en_r <= wdata_r[7:0] & `CFISR_FLAG_MASK;
    end
  end

  // ----------------------------------------------------------------
  // error state and flag sources
  // ----------------------------------------------------------------
  assign any_warning = tx_warning | rx_warning;

  assign err_levels = {tx_bus_off, tx_error_passive, rx_error_passive,
                       tx_warning, rx_warning, any_warning};

  // entering any error state raises the error flag once
  cfisr_rise #(
    .W (6)
  ) u_err_rise (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .level    (err_levels),
    .any_rise (err_rise)
  );

  always_comb begin
    flag_set                  = 8'h00;
    flag_set[`CFISR_IVR_BIT]  = invalid_msg_evt;
    flag_set[`CFISR_WAK_BIT]  = wakeup_evt;
    flag_set[`CFISR_ERR_BIT]  = err_rise;
    flag_set[`CFISR_FIFO_BIT] = fifo_almost_full_evt;
    flag_set[`CFISR_RBOV_BIT] = rx_overflow_evt;
    flag_set[`CFISR_RB_BIT]   = rx_buffer_evt;
    flag_set[`CFISR_TB_BIT]   = tx_buffer_evt;
  end

  // writing zero clears a flag; writing one leaves it alone
  assign flag_clr = (wr_flags && wstrb_r[0])
                    ? (~wdata_r[7:0] & `CFISR_FLAG_MASK) : 8'h00;

  cfisr_flags u_flags (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set_evt (flag_set),
    .clr     (flag_clr),
    .flag_r  (flag_r)
  );

  // level request; drops when the flag or its enable goes
  assign irq = |(flag_r & en_r);

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    flags_word                   = 16'h0000;
    flags_word[`CFISR_TX_BUS_OFF_BIT]  = tx_bus_off;
    flags_word[`CFISR_TX_ERROR_PASSIVE_BIT]  = tx_error_passive;
    flags_word[`CFISR_RX_ERROR_PASSIVE_BIT]  = rx_error_passive;
    flags_word[`CFISR_TX_WARNING_BIT] = tx_warning;
    flags_word[`CFISR_RX_WARNING_BIT] = rx_warning;
    flags_word[`CFISR_ANY_WARNING_BIT] = any_warning;
    flags_word[7:0]              = flag_r;
  end

  always_comb begin
    rd_word = 16'h0000;
    if (addr_is(s_axi_araddr, `CFISR_OFF_FIFO_CTRL)) begin
      rd_word[`CFISR_DMA_BUFFER_COUNT_SEL_LSB +: 3] = dma_buffer_count_sel_r;
      rd_word[`CFISR_FSA_LSB +: 5]   = fsa_r;
    end else if (addr_is(s_axi_araddr, `CFISR_OFF_FIFO_PTR)) begin
      rd_word[`CFISR_FBP_LSB +: 6]  = fifo_write_pointer;
      rd_word[`CFISR_FIFO_NEXT_READ_POINTER_LSB +: 6] = fifo_next_read_pointer;
    end else if (addr_is(s_axi_araddr, `CFISR_OFF_INT_FLAGS)) begin
      rd_word = flags_word;
    end else if (addr_is(s_axi_araddr, `CFISR_OFF_INT_ENABLES)) begin
      rd_word[7:0] = en_r;
    end
  end

  // one read at a time; data registered the edge the address is taken
  assign s_axi_arready = !rvalid_r;
  assign ar_take       = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `CFISR_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= {16'h0000, rd_word};
      rresp_r  <= addr_ok(s_axi_araddr) ? `CFISR_RESP_OKAY
                                        : `CFISR_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_TX_BUS_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && addr_is(s_axi_araddr, `CFISR_OFF_INT_FLAGS)
    |=> s_axi_rdata[13] == $past(tx_bus_off))
    else $error("bus-off bit wrong on read");

  AST_TX_ERROR_PASSIVE: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && addr_is(s_axi_araddr, `CFISR_OFF_INT_FLAGS)
    |=> s_axi_rdata[12] == $past(tx_error_passive))
    else $error("tx passive bit wrong on read");

  AST_RX_ERROR_PASSIVE: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && addr_is(s_axi_araddr, `CFISR_OFF_INT_FLAGS)
    |=> s_axi_rdata[11] == $past(rx_error_passive))
    else $error("rx passive bit wrong on read");

  AST_TX_WARNING: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && addr_is(s_axi_araddr, `CFISR_OFF_INT_FLAGS)
    |=> s_axi_rdata[10] == $past(tx_warning))
    else $error("tx warning bit wrong on read");

  AST_RX_WARNING: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && addr_is(s_axi_araddr, `CFISR_OFF_INT_FLAGS)
    |=> s_axi_rdata[9] == $past(rx_warning))
    else $error("rx warning bit wrong on read");

  AST_ANY_WARNING: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && addr_is(s_axi_araddr, `CFISR_OFF_INT_FLAGS)
    |=> s_axi_rdata[8] == (s_axi_rdata[10] | s_axi_rdata[9]))
    else $error("any warning bit not the or of both");

  AST_IVR_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    invalid_msg_evt |=> flag_r[7] [*2] or (flag_r[7] ##1 $fell(flag_r[7])))
    else $error("invalid message flag not set");

  AST_IVR_NOSET: assert property (@(posedge aclk) disable iff (!aresetn)
    !flag_r[7] && !invalid_msg_evt |=> !flag_r[7])
    else $error("invalid message flag set without event");

  AST_WAK: assert property (@(posedge aclk) disable iff (!aresetn)
    wakeup_evt |=> flag_r[6])
    else $error("wake-up flag not set");

  AST_ERR: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(tx_bus_off) || $rose(rx_warning) |=> flag_r[5])
    else $error("error flag not set on state entry");

  AST_FIFO: assert property (@(posedge aclk) disable iff (!aresetn)
    fifo_almost_full_evt |=> flag_r[3])
    else $error("almost full flag not set");

  AST_RBOV: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_overflow_evt |=> flag_r[2])
    else $error("overflow flag not set");

  AST_RB: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_buffer_evt |=> flag_r[1])
    else $error("receive flag lost against a clear");

  AST_TB: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(flag_r[0]) |-> $past(tx_buffer_evt))
    else $error("transmit flag set without event");

  AST_FIFO_NEXT_READ_POINTER: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && addr_is(s_axi_araddr, `CFISR_OFF_FIFO_PTR)
    |=> s_axi_rdata[5:0] == $past(fifo_next_read_pointer)
        && s_axi_rdata[13:8] == $past(fifo_write_pointer))
    else $error("pointer status wrong on read");

  AST_UNIMP: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && !flag_r[4]
      && !en_r[4])
    else $error("unimplemented bit reads nonzero");

  AST_UNIMP_FLAGS: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && addr_is(s_axi_araddr, `CFISR_OFF_INT_FLAGS)
    |=> !s_axi_rdata[4] && s_axi_rdata[15:14] == 2'h0)
    else $error("unimplemented flag bit reads nonzero");

  AST_EN: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_en && wstrb_r[0] |=> en_r == ($past(wdata_r[7:0]) & 8'hEF))
    else $error("enable register not written");

  AST_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
    flag_set[0] && en_r[0] && !wr_en |=> irq)
    else $error("interrupt request missing");

  AST_IRQ_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
    irq |-> |(flag_r & en_r))
    else $error("interrupt request without cause");

  AST_CTRL: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ctrl && wstrb_r[1:0] == 2'h3
    |=> dma_buffer_count_sel == $past(wdata_r[15:13])
        && fifo_area_start == $past(wdata_r[4:0]))
    else $error("fifo control fields not written");

endmodule // cfisr_regs
`default_nettype wire

// ### cfisr_engine_model.sv
/*
  behavioural protocol engine beside the status/interrupt registers.
  assumes the bench asks for events and levels one cycle ahead.
*/
`timescale 1ns/10ps
`default_nettype none
module cfisr_engine_model (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // requests from the bench
  input  wire logic [5:0] cmd_evt,
  input  wire logic [4:0] cmd_lvl,
  input  wire logic [5:0] cmd_wptr,
  input  wire logic [5:0] cmd_rptr,
  // engine outputs
  output logic [5:0]      evt,
  output logic [4:0]      lvl,
  output logic [5:0]      wptr,
  output logic [5:0]      rptr
);
  // registered like real engine state; events last one cycle only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt  <= 6'h00;
      lvl  <= 5'h00;
      wptr <= 6'h00;
      rptr <= 6'h00;
    end else begin
      evt  <= cmd_evt;
      lvl  <= cmd_lvl;
      wptr <= cmd_wptr;
      rptr <= cmd_rptr;
    end
  end
endmodule // cfisr_engine_model
`default_nettype wire

// ### tb.sv
/*
  self-checking bench of the status and interrupt registers.
  assumes the engine model and the register block compile before it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cfisr_consts.svh"
module tb;
  import cfisr_pkg::*;
  typedef struct packed {
    logic [5:0]  ev;
    logic [4:0]  lv;
    logic [15:0] ex;
  } cfisr_row_type;
  logic aclk, aresetn, irq;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [5:0] cmd_evt, cmd_wptr, cmd_rptr, evt, wptr, rptr;
  logic [4:0] cmd_lvl, lvl, fifo_area_start;
  logic [2:0] dma_buffer_count_sel;
  int err_count, n_tests;
  // one row per event or level source: request and flag word expected
  cfisr_row_type rows [11] = '{
    '{6'h20, 5'h00, 16'h0080}, '{6'h10, 5'h00, 16'h0040},
    '{6'h08, 5'h00, 16'h0008}, '{6'h04, 5'h00, 16'h0004},
    '{6'h02, 5'h00, 16'h0002}, '{6'h01, 5'h00, 16'h0001},
    '{6'h00, 5'h10, 16'h2020}, '{6'h00, 5'h08, 16'h1020},
    '{6'h00, 5'h04, 16'h0820}, '{6'h00, 5'h02, 16'h0520},
    '{6'h00, 5'h01, 16'h0320}};

  // ------------------------------------------------------------
  // instances
  // ------------------------------------------------------------
  cfisr_engine_model ENG (.aclk, .aresetn, .cmd_evt, .cmd_lvl,
    .cmd_wptr, .cmd_rptr, .evt, .lvl, .wptr, .rptr);
  cfisr_regs DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .tx_bus_off(lvl[4]), .tx_error_passive(lvl[3]),
    .rx_error_passive(lvl[2]), .tx_warning(lvl[1]), .rx_warning(lvl[0]),
    .invalid_msg_evt(evt[5]), .wakeup_evt(evt[4]),
    .fifo_almost_full_evt(evt[3]), .rx_overflow_evt(evt[2]),
    .rx_buffer_evt(evt[1]), .tx_buffer_evt(evt[0]),
    .fifo_write_pointer(wptr), .fifo_next_read_pointer(rptr),
    .dma_buffer_count_sel, .fifo_area_start, .irq);

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // readiness judged at the falling edge, so the take edge is known
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic pa;
    logic pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      if (s_axi_awready) pa = 1'b0;
      if (s_axi_wready) pw = 1'b0;
      @(posedge aclk);
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input logic [31:0] a, input logic [31:0] exp);
    rd(a);
    chk(rdat, exp);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // whole run is well under two thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready} = 2'b00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hF;
    {cmd_evt, cmd_lvl, cmd_wptr, cmd_rptr} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`CFISR_OFF_FIFO_CTRL, 32'h0000_0000);
    rc(`CFISR_OFF_INT_FLAGS, 32'h0000_0000);
    rc(`CFISR_OFF_INT_ENABLES, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    foreach (rows[i]) begin
      wr(`CFISR_OFF_INT_ENABLES, 32'h0000_00EF);
      @(posedge aclk);
      cmd_evt <= rows[i].ev;
      cmd_lvl <= rows[i].lv;
      @(posedge aclk);
      cmd_evt <= 6'h00;
      repeat (3) @(posedge aclk);
      rc(`CFISR_OFF_INT_FLAGS, {16'h0000, rows[i].ex});
      chk(32'(irq), 32'h0000_0001);
      wr(`CFISR_OFF_INT_FLAGS, 32'hFFFF_FFFF);
      rc(`CFISR_OFF_INT_FLAGS, {16'h0000, rows[i].ex});
      wr(`CFISR_OFF_INT_ENABLES, 32'h0000_0000);
      @(negedge aclk);
      chk(32'(irq), 32'h0000_0000);
      @(posedge aclk);
      cmd_lvl <= 5'h00;
      wr(`CFISR_OFF_INT_FLAGS, 32'h0000_0000);
      rc(`CFISR_OFF_INT_FLAGS, 32'h0000_0000);
    end
    // error flag fires on entry only, not while a level is held
    @(posedge aclk);
    cmd_lvl <= 5'h10;
    cmd_wptr <= 6'h1E;
    cmd_rptr <= 6'h1F;
    repeat (4) @(posedge aclk);
    wr(`CFISR_OFF_INT_FLAGS, 32'h0000_0000);
    rc(`CFISR_OFF_INT_FLAGS, 32'h0000_2000);
    rc(`CFISR_OFF_FIFO_PTR, 32'h0000_1E1F);
    wr(`CFISR_OFF_FIFO_PTR, 32'h0000_0000);
    rc(`CFISR_OFF_FIFO_PTR, 32'h0000_1E1F);
    wr(`CFISR_OFF_FIFO_CTRL, 32'hFFFF_FFFF);
    chk(32'(resp), 32'(`CFISR_RESP_OKAY));
    rc(`CFISR_OFF_FIFO_CTRL, 32'h0000_E01F);
    chk(32'(dma_buffer_count_sel), 32'h0000_0007);
    chk(32'(fifo_area_start), 32'h0000_001F);
    wr(`CFISR_OFF_INT_ENABLES, 32'hFFFF_FFFF);
    rc(`CFISR_OFF_INT_ENABLES, 32'h0000_00EF);
    // unmapped word answers with an error and reads zero
    wr(32'h0000_0010, 32'hFFFF_FFFF);
    chk(32'(resp), 32'(`CFISR_RESP_SLVERR));
    rd(32'h0000_0010);
    chk(rdat, 32'h0000_0000);
    chk(32'(resp), 32'(`CFISR_RESP_SLVERR));
    // second reset in mid-run clears configuration and enables
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`CFISR_OFF_FIFO_CTRL, 32'h0000_0000);
    rc(`CFISR_OFF_INT_ENABLES, 32'h0000_0000);
    test_done;
  end
endmodule // tb
`default_nettype wire
